/* File: core/lims_consts.svh */
// Offsets, field positions and reset values of the mode select block
`ifndef LIMS_CONSTS_SVH
`define LIMS_CONSTS_SVH

// ----------------------------------------------------------------------
// Register bus
// ----------------------------------------------------------------------
`define LIMS_ADDR_W        4
`define LIMS_DATA_W        8
`define LIMS_ADDR_CFG      4'h0
`define LIMS_ADDR_STAT     4'h1
`define LIMS_CFG_RESET     8'h00
`define LIMS_RDATA_ZERO    8'h00

// ----------------------------------------------------------------------
// Configuration register fields
// ----------------------------------------------------------------------
`define LIMS_CFG_RATE      0
`define LIMS_CFG_MEDIA     1
`define LIMS_CFG_PAR       2
`define LIMS_CFG_RSEL_LO   3
`define LIMS_CFG_RSEL_HI   4
`define LIMS_CFG_SERM_LO   5
`define LIMS_CFG_SERM_HI   6
`define LIMS_CFG_PCLK      7

// ----------------------------------------------------------------------
// Status register fields
// ----------------------------------------------------------------------
`define LIMS_ST_RATE       0
`define LIMS_ST_MEDIA      1
`define LIMS_ST_PAR        2
`define LIMS_ST_SWMODE     3
`define LIMS_ST_REFOK      4
`define LIMS_ST_MASTER     5
`define LIMS_ST_CDRBYP     6
`define LIMS_ST_FIFOBYP    7

// ----------------------------------------------------------------------
// Pin vector layout and three-level pin codes
// ----------------------------------------------------------------------
`define LIMS_PIN_W         8
`define LIMS_PIN_HWSW      0
`define LIMS_PIN_RATE      1
`define LIMS_PIN_MEDIA     2
`define LIMS_PIN_IFSEL     3
`define LIMS_PIN_RSEL_LO   4
`define LIMS_PIN_RSEL_HI   5
`define LIMS_PIN_CKM_LO    6
`define LIMS_PIN_CKM_HI    7
`define LIMS_TRI_LOW       2'h0
`define LIMS_TRI_FLOAT     2'h2
`define LIMS_TRI_HIGH      2'h3
`define LIMS_SERM_CLKDATA  2'h0
`define LIMS_SERM_DATA     2'h2
`define LIMS_SERM_PLESIO   2'h1

`endif

/* File: core/lims_pkg.sv */
// Types shared by the mode select block
package lims_pkg;

   // Expected reference clock frequency
   typedef enum logic [2:0] {
      lims_ref_19m44,
      lims_ref_17m408,
      lims_ref_77m76,
      lims_ref_155m52,
      lims_ref_139m264,
      lims_ref_invalid
   } lims_refclk_type;

   // Transmit clocking scheme
   typedef enum logic [2:0] {
      lims_tx_ser_clkdata,
      lims_tx_ser_data,
      lims_tx_ser_plesio,
      lims_tx_par_slave,
      lims_tx_par_master,
      lims_tx_invalid
   } lims_txclk_type;

endpackage : lims_pkg

/* File: core/lims_sync.sv */
// Two-stage synchroniser for the control pins
`timescale 1ns/100ps
`include "lims_consts.svh"

module lims_sync (
   input  wire logic                     clk,
   input  wire logic                     arst_n,
   input  wire logic [`LIMS_PIN_W-1:0]   pin_async,
   output logic      [`LIMS_PIN_W-1:0]   pin_sync
);

   // ----------------------------------------------------------------------
   // One synchroniser per pin bit
   // ----------------------------------------------------------------------
   genvar i;
   generate
      for (i = 0; i < `LIMS_PIN_W; i = i + 1) begin : g_bit
         logic meta_reg;
         logic meta_next;
         logic sync_reg;
         logic sync_next;

         // First stage feeds only the second stage
         always_comb begin
            meta_next = pin_async[i];
            sync_next = meta_reg;
         end

         always_ff @(posedge clk or negedge arst_n) begin
            if (!arst_n) begin
               meta_reg <= 1'b0;
               sync_reg <= 1'b0;
            end else begin
               meta_reg <= meta_next;
               sync_reg <= sync_next;
            end
         end

         assign pin_sync[i] = sync_reg;
      end
   endgenerate

endmodule : lims_sync

/* File: core/lims_mode_select.sv */
// Mode select logic: resolves rate, media, interface and reference settings
//
// Function
// R1: Select pin low takes settings from pins
// R2: Select pin high uses register bits only
// R3: Rate pin/bit high selects 139.264, else 155.52
// R4: Reference frequency from rate and clock select
// R5: Clock select 00/10/11 map reference frequencies
// R6: Media high CMI coax, low NRZ fiber
// R7: Interface high parallel nibble, low serial
// R8: Serial mode 00 clk+data, 10 data, 01 plesio
// R9: Parallel clock mode 0 slave, 1 master
// R10: Pin or bit chosen, then registered
//
// Pins pass two flops, so outputs lag pins by three edges.
// A config write shows one edge after the write edge.
// Three-level straps come as codes 00 low, 10 float, 11 high.
// Config bits stay readable while the pins rule.
//
// The address-and-strobe port and the address map were decided locally.
`timescale 1ns/100ps
`include "lims_consts.svh"

module lims_mode_select (
   input  wire logic                        clk,
   input  wire logic                        arst_n,
   input  wire logic                        hw_sw_select_pin,
   input  wire logic                        rate_select_pin,
   input  wire logic                        media_select_pin,
   input  wire logic                        interface_select_pin,
   input  wire logic [1:0]                  refclk_freq_select,
   input  wire logic [1:0]                  tx_clock_mode_pin,
   input  wire logic [`LIMS_ADDR_W-1:0]     reg_addr,
   input  wire logic [`LIMS_DATA_W-1:0]     reg_wdata,
   input  wire logic                        reg_wr,
   input  wire logic                        reg_rd,
   output logic      [`LIMS_DATA_W-1:0]     reg_rdata,
   output logic                             sw_mode,
   output logic                             rate_e4,
   output logic                             media_cmi,
   output logic                             parallel_if,
   output lims_pkg::lims_refclk_type        refclk_freq,
   output logic                             refclk_valid,
   output lims_pkg::lims_txclk_type         tx_clock_scheme,
   output logic                             tx_cdr_bypass,
   output logic                             tx_fifo_bypass,
   output logic                             parallel_master
);

   // ----------------------------------------------------------------------
   // Pin synchronisation
   // ----------------------------------------------------------------------
   logic [`LIMS_PIN_W-1:0] pin_async;
   logic [`LIMS_PIN_W-1:0] pin_sync;

   // Pack pins for the synchroniser
   // Bit order follows the pin vector layout
   assign pin_async = {tx_clock_mode_pin, refclk_freq_select, interface_select_pin,
                       media_select_pin, rate_select_pin, hw_sw_select_pin};

   // Every pin passes two flops before any decode reads it
   lims_sync u_sync (
      .clk       (clk),
      .arst_n    (arst_n),
      .pin_async (pin_async),
      .pin_sync  (pin_sync)
   );

   // ----------------------------------------------------------------------
   // Configuration register and read port
   // ----------------------------------------------------------------------
   logic [`LIMS_DATA_W-1:0] cfg_reg;
   logic [`LIMS_DATA_W-1:0] cfg_next;
   logic [`LIMS_DATA_W-1:0] rdata_reg;
   logic [`LIMS_DATA_W-1:0] rdata_next;
   logic [`LIMS_DATA_W-1:0] stat_word;

   // Write decode and read mux, unmapped reads return zero
   // Writes to status or unmapped addresses are dropped
   always_comb begin
      cfg_next   = cfg_reg;
      rdata_next = `LIMS_RDATA_ZERO;
      if (reg_wr && reg_addr == `LIMS_ADDR_CFG) begin
         cfg_next = reg_wdata;
      end
      if (reg_rd) begin
         if (reg_addr == `LIMS_ADDR_CFG) begin
            rdata_next = cfg_reg;
         end else if (reg_addr == `LIMS_ADDR_STAT) begin
            rdata_next = stat_word;
         end else begin
            rdata_next = `LIMS_RDATA_ZERO;
         end
      end
   end

   // Config and read data registers; read data stands one cycle
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         cfg_reg   <= `LIMS_CFG_RESET;
         rdata_reg <= `LIMS_RDATA_ZERO;
      end else begin
         cfg_reg   <= cfg_next;
         rdata_reg <= rdata_next;
      end
   end

   // ----------------------------------------------------------------------
   // Source selection: pins in hardware mode, bits in software mode
   // ----------------------------------------------------------------------
   logic       sel_sw;
   logic       sel_rate;
   logic       sel_media;
   logic       sel_par;
   logic [1:0] sel_rsel;
   logic [1:0] sel_serm;
   logic       sel_pclk;
   // Synchronised three-level pin fields
   logic [1:0] pin_rsel;
   logic [1:0] pin_ckm;

   assign pin_rsel = pin_sync[`LIMS_PIN_RSEL_HI:`LIMS_PIN_RSEL_LO];
   assign pin_ckm  = pin_sync[`LIMS_PIN_CKM_HI:`LIMS_PIN_CKM_LO];

   // Choose each setting from its pin or its register bit
   // Select pin shares the synchroniser with the pins it gates,
   // so a mode change never mixes both sources for a cycle
   always_comb begin
      sel_sw = pin_sync[`LIMS_PIN_HWSW];
      if (sel_sw) begin                                        // see R2
         sel_rate  = cfg_reg[`LIMS_CFG_RATE];                  // see R10
         sel_media = cfg_reg[`LIMS_CFG_MEDIA];
         sel_par   = cfg_reg[`LIMS_CFG_PAR];
         sel_rsel  = cfg_reg[`LIMS_CFG_RSEL_HI:`LIMS_CFG_RSEL_LO];
         sel_serm  = cfg_reg[`LIMS_CFG_SERM_HI:`LIMS_CFG_SERM_LO];
         sel_pclk  = cfg_reg[`LIMS_CFG_PCLK];
      end else begin                                           // see R1
         sel_rate  = pin_sync[`LIMS_PIN_RATE];                 // see R10
         sel_media = pin_sync[`LIMS_PIN_MEDIA];
         sel_par   = pin_sync[`LIMS_PIN_IFSEL];
         sel_rsel  = pin_rsel;
         // Three-level clock mode pin maps onto serial mode codes
         if (pin_ckm == `LIMS_TRI_LOW) begin
            sel_serm = `LIMS_SERM_CLKDATA;
         end else if (pin_ckm == `LIMS_TRI_FLOAT) begin
            sel_serm = `LIMS_SERM_DATA;
         end else if (pin_ckm == `LIMS_TRI_HIGH) begin
            sel_serm = `LIMS_SERM_PLESIO;
         end else begin
            // Code 01 is passed on and reads as plesiochronous
            sel_serm = pin_ckm;
         end
         sel_pclk = (pin_ckm == `LIMS_TRI_HIGH);              // see R9
      end
   end

   // ----------------------------------------------------------------------
   // Reference frequency and transmit clocking decode
   // ----------------------------------------------------------------------
   lims_pkg::lims_refclk_type ref_dec;
   lims_pkg::lims_txclk_type  tx_dec;
   logic                      cdr_byp_dec;
   logic                      fifo_byp_dec;

   // Reference depends on rate and clock select together
   // Code 01 is no legal strap and falls to invalid
   always_comb begin
      case (sel_rsel)                                          // see R4
         `LIMS_TRI_LOW:   ref_dec = sel_rate ? lims_pkg::lims_ref_17m408
                                             : lims_pkg::lims_ref_19m44;     // see R5
         `LIMS_TRI_FLOAT: ref_dec = sel_rate ? lims_pkg::lims_ref_invalid
                                             : lims_pkg::lims_ref_77m76;     // see R5
         `LIMS_TRI_HIGH:  ref_dec = sel_rate ? lims_pkg::lims_ref_139m264
                                             : lims_pkg::lims_ref_155m52;    // see R5
         default:         ref_dec = lims_pkg::lims_ref_invalid;
      endcase
   end

   // Transmit clocking per interface type
   always_comb begin
      cdr_byp_dec  = 1'b0;
      fifo_byp_dec = 1'b0;
      if (sel_par) begin                                       // see R7
         // Parallel clocking ignores the serial mode code
         tx_dec = sel_pclk ? lims_pkg::lims_tx_par_master
                           : lims_pkg::lims_tx_par_slave;      // see R9
      end else begin
         case (sel_serm)                                       // see R8
            `LIMS_SERM_CLKDATA: begin
               tx_dec      = lims_pkg::lims_tx_ser_clkdata;
               cdr_byp_dec = 1'b1;
            end
            `LIMS_SERM_DATA: begin
               tx_dec = lims_pkg::lims_tx_ser_data;
            end
            `LIMS_SERM_PLESIO: begin
               tx_dec       = lims_pkg::lims_tx_ser_plesio;
               fifo_byp_dec = 1'b1;
            end
            default: begin
               // Code 11 has no scheme; both bypasses stay low
               tx_dec = lims_pkg::lims_tx_invalid;
            end
         endcase
      end
   end

   // ----------------------------------------------------------------------
   // Effective settings, registered before use
   // ----------------------------------------------------------------------
   logic                      sw_reg;
   logic                      rate_reg;
   logic                      media_reg;
   logic                      par_reg;
   lims_pkg::lims_refclk_type ref_reg;
   logic                      refok_reg;
   lims_pkg::lims_txclk_type  tx_reg;
   logic                      cdr_reg;
   logic                      fifo_reg;
   logic                      master_reg;

   // Next values
   logic                      sw_next;
   logic                      rate_next;
   logic                      media_next;
   logic                      par_next;
   lims_pkg::lims_refclk_type ref_next;
   logic                      refok_next;
   lims_pkg::lims_txclk_type  tx_next;
   logic                      cdr_next;
   logic                      fifo_next;
   logic                      master_next;

   // Next effective values
   always_comb begin
      sw_next     = sel_sw;
      rate_next   = sel_rate;                                  // see R3
      media_next  = sel_media;                                 // see R6
      par_next    = sel_par;                                   // see R7
      ref_next    = ref_dec;
      refok_next  = (ref_dec != lims_pkg::lims_ref_invalid);   // see R5
      tx_next     = tx_dec;
      cdr_next    = cdr_byp_dec;
      fifo_next   = fifo_byp_dec;
      master_next = sel_par & sel_pclk;                        // see R9
   end

   // Register effective values
   // Reset gives a valid pin-mode serial setup at 19.44 MHz
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         sw_reg     <= 1'b0;
         rate_reg   <= 1'b0;
         media_reg  <= 1'b0;
         par_reg    <= 1'b0;
         ref_reg    <= lims_pkg::lims_ref_19m44;
         refok_reg  <= 1'b1;
         tx_reg     <= lims_pkg::lims_tx_ser_clkdata;
         cdr_reg    <= 1'b1;
         fifo_reg   <= 1'b0;
         master_reg <= 1'b0;
      end else begin
         sw_reg     <= sw_next;                                // see R10
         rate_reg   <= rate_next;
         media_reg  <= media_next;
         par_reg    <= par_next;
         ref_reg    <= ref_next;
         refok_reg  <= refok_next;
         tx_reg     <= tx_next;
         cdr_reg    <= cdr_next;
         fifo_reg   <= fifo_next;
         master_reg <= master_next;
      end
   end

   // Status word shows the effective settings
   // Built from registered values, never from the raw decode
   always_comb begin
      stat_word                   = `LIMS_RDATA_ZERO;
      stat_word[`LIMS_ST_RATE]    = rate_reg;
      stat_word[`LIMS_ST_MEDIA]   = media_reg;
      stat_word[`LIMS_ST_PAR]     = par_reg;
      stat_word[`LIMS_ST_SWMODE]  = sw_reg;
      stat_word[`LIMS_ST_REFOK]   = refok_reg;
      stat_word[`LIMS_ST_MASTER]  = master_reg;
      stat_word[`LIMS_ST_CDRBYP]  = cdr_reg;
      stat_word[`LIMS_ST_FIFOBYP] = fifo_reg;
   end

   // ----------------------------------------------------------------------
   // Outputs
   // ----------------------------------------------------------------------
   // Every output comes straight from a flip-flop
   // No combinational path from any input to an output
   assign reg_rdata       = rdata_reg;
   assign sw_mode         = sw_reg;
   assign rate_e4         = rate_reg;
   assign media_cmi       = media_reg;
   assign parallel_if     = par_reg;
   assign refclk_freq     = ref_reg;
   assign refclk_valid    = refok_reg;
   assign tx_clock_scheme = tx_reg;
   assign tx_cdr_bypass   = cdr_reg;
   assign tx_fifo_bypass  = fifo_reg;
   assign parallel_master = master_reg;

endmodule : lims_mode_select

/* File: verif/lims_monitor.sv */
// Checker of the mode select outputs against pins and register bus
`timescale 1ns/100ps
`include "lims_consts.svh"
module lims_monitor (
   input wire logic                    clk,
   input wire logic                    arst_n,
   input wire logic                    hw_sw_select_pin,
   input wire logic                    rate_select_pin,
   input wire logic                    media_select_pin,
   input wire logic                    interface_select_pin,
   input wire logic [1:0]              refclk_freq_select,
   input wire logic                    reg_wr,
   input wire logic                    reg_rd,
   input wire logic [`LIMS_DATA_W-1:0] reg_rdata,
   input wire logic                    sw_mode,
   input wire logic                    rate_e4,
   input wire logic                    media_cmi,
   input wire logic                    parallel_if,
   input wire lims_pkg::lims_refclk_type refclk_freq,
   input wire lims_pkg::lims_txclk_type  tx_clock_scheme,
   input wire logic                    tx_cdr_bypass,
   input wire logic                    tx_fifo_bypass
);
   logic [1:0] up_reg;
   logic [1:0] up_next;
   logic       ok3;
   default clocking cb @(posedge clk); endclocking
   default disable iff (!arst_n);
   // ---------------------------------------------
   // Edges since reset, so pin history is valid
   // ---------------------------------------------
   always_comb up_next = (up_reg == 2'h3) ? up_reg : up_reg + 2'h1;
   always_ff @(posedge clk or negedge arst_n)
      if (!arst_n) up_reg <= 2'h0;
      else up_reg <= up_next;
   assign ok3 = up_reg == 2'h3;
   // ---------------------------------------------
   // Assertions
   // ---------------------------------------------
   a_sw_track: assert property (ok3 |-> sw_mode == $past(hw_sw_select_pin, 3))
      else $error("sw_mode lags select pin wrongly");
   a_pin_follow: assert property (ok3 && !$past(hw_sw_select_pin, 3) |->
      {rate_e4, media_cmi, parallel_if} == {$past(rate_select_pin, 3),
      $past(media_select_pin, 3), $past(interface_select_pin, 3)})
      else $error("pin settings not followed");
   a_ref_high: assert property (ok3 && !$past(hw_sw_select_pin, 3) &&
      $past(refclk_freq_select, 3) == 2'h3 |-> refclk_freq ==
      (rate_e4 ? lims_pkg::lims_ref_139m264 : lims_pkg::lims_ref_155m52))
      else $error("high clock select wrong reference");
   a_ref_low: assert property (ok3 && !$past(hw_sw_select_pin, 3) &&
      $past(refclk_freq_select, 3) == 2'h0 |-> refclk_freq ==
      (rate_e4 ? lims_pkg::lims_ref_17m408 : lims_pkg::lims_ref_19m44))
      else $error("low clock select wrong reference");
   a_sw_hold: assert property (ok3 && sw_mode && $past(sw_mode) && !$past(reg_wr) &&
      !$past(reg_wr, 2) |-> $stable(rate_e4) && $stable(media_cmi) && $stable(parallel_if))
      else $error("software mode setting moved without write");
   a_tx_bypass: assert property ((tx_clock_scheme == lims_pkg::lims_tx_ser_clkdata)
      == tx_cdr_bypass && (tx_clock_scheme == lims_pkg::lims_tx_ser_plesio) == tx_fifo_bypass)
      else $error("bypass flags disagree with scheme");
   a_if_scheme: assert property (parallel_if == (tx_clock_scheme inside
      {lims_pkg::lims_tx_par_slave, lims_pkg::lims_tx_par_master}))
      else $error("interface and scheme disagree");
   a_rd_pulse: assert property (!$past(reg_rd) |-> reg_rdata == `LIMS_RDATA_ZERO)
      else $error("read data outside read cycle");
endmodule : lims_monitor

bind lims_mode_select lims_monitor u_mon (.clk, .arst_n, .hw_sw_select_pin, .rate_select_pin,
   .media_select_pin, .interface_select_pin, .refclk_freq_select, .reg_wr, .reg_rd, .reg_rdata,
   .sw_mode, .rate_e4, .media_cmi, .parallel_if, .refclk_freq, .tx_clock_scheme,
   .tx_cdr_bypass, .tx_fifo_bypass);

/* File: verif/lims_ctrl_model.sv */
// Board controller model: straps the control pins and drives the register bus
`timescale 1ns/100ps
`include "lims_consts.svh"
module lims_ctrl_model (
   input  wire logic                    clk,
   input  wire logic [`LIMS_DATA_W-1:0] reg_rdata,
   output logic                         hw_sw_select_pin,
   output logic [2:0]                   rmi_pins,
   output logic [1:0]                   refclk_freq_select,
   output logic [1:0]                   tx_clock_mode_pin,
   output logic [`LIMS_ADDR_W-1:0]      reg_addr,
   output logic [`LIMS_DATA_W-1:0]      reg_wdata,
   output logic                         reg_wr,
   output logic                         reg_rd
);
   // Pin mode and quiet bus at time zero
   initial begin
      {hw_sw_select_pin, rmi_pins, refclk_freq_select, tx_clock_mode_pin} = 8'h00;
      {reg_addr, reg_wdata, reg_wr, reg_rd} = 14'h0000;
   end
   // Straps; select pin low means pin control, high means bus control
   task automatic set_pins(input logic sw, input logic [2:0] rmi, input logic [1:0] ck,
                           input logic [1:0] cm);
      @(posedge clk);
      hw_sw_select_pin <= sw;
      rmi_pins <= rmi;
      refclk_freq_select <= ck;
      tx_clock_mode_pin <= cm;
   endtask : set_pins
   // One-cycle write; released lines flip so stale values never look valid
   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge clk);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge clk);
      reg_wr <= 1'b0;
      reg_addr <= ~a;
      reg_wdata <= ~d;
   endtask : wr
   // One-cycle read, data taken in the following cycle
   task automatic rd(input logic [3:0] a, output logic [7:0] d);
      @(posedge clk);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge clk);
      reg_rd <= 1'b0;
      reg_addr <= ~a;
      #1 d = reg_rdata;
   endtask : rd
endmodule : lims_ctrl_model

/* File: verif/tb_lims_mode_select.sv */
// Self-checking bench of the mode select block
`timescale 1ns/100ps
`include "lims_consts.svh"
`define CHK(got, exp) begin compares++; if ((got) !== (exp)) begin n_fail++; \
   $display("Error %0t: got %h expected %h", $time, got, exp); end end
module tb_lims_mode_select;
   logic clk, arst_n, hw_sw_select_pin, reg_wr, reg_rd;
   logic sw_mode, rate_e4, media_cmi, parallel_if, refclk_valid;
   logic tx_cdr_bypass, tx_fifo_bypass, parallel_master;
   logic [2:0] rmi_pins;
   logic [1:0] refclk_freq_select, tx_clock_mode_pin;
   logic [3:0] reg_addr;
   logic [7:0] reg_wdata, reg_rdata, rb;
   lims_pkg::lims_refclk_type refclk_freq;
   lims_pkg::lims_txclk_type  tx_clock_scheme;
   logic [31:0] seed = 32'h00000061;
   int n_fail = 0;
   int compares = 0;
   lims_mode_select uut (.clk, .arst_n, .hw_sw_select_pin, .rate_select_pin(rmi_pins[2]),
      .media_select_pin(rmi_pins[1]), .interface_select_pin(rmi_pins[0]), .refclk_freq_select,
      .tx_clock_mode_pin, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .sw_mode,
      .rate_e4, .media_cmi, .parallel_if, .refclk_freq, .refclk_valid, .tx_clock_scheme,
      .tx_cdr_bypass, .tx_fifo_bypass, .parallel_master);
   lims_ctrl_model ctrl (.clk, .reg_rdata, .hw_sw_select_pin, .rmi_pins, .refclk_freq_select,
      .tx_clock_mode_pin, .reg_addr, .reg_wdata, .reg_wr, .reg_rd);
   // ---------------------------------------------
   // Expectation helpers
   // ---------------------------------------------
   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction : rnd
   function automatic logic [1:0] tri3(input logic [1:0] r);
      return (r == 2'h0) ? `LIMS_TRI_LOW : (r == 2'h1) ? `LIMS_TRI_FLOAT : `LIMS_TRI_HIGH;
   endfunction : tri3
   function automatic lims_pkg::lims_refclk_type exp_ref(input logic e4, input logic [1:0] ck);
      if (ck == 2'h1 || (ck == 2'h2 && e4)) return lims_pkg::lims_ref_invalid;
      if (ck == 2'h0) return e4 ? lims_pkg::lims_ref_17m408 : lims_pkg::lims_ref_19m44;
      if (ck == 2'h2) return lims_pkg::lims_ref_77m76;
      return e4 ? lims_pkg::lims_ref_139m264 : lims_pkg::lims_ref_155m52;
   endfunction : exp_ref
   function automatic lims_pkg::lims_txclk_type exp_tx(input logic p, input logic [1:0] sm,
                                                       input logic pm);
      if (p) return pm ? lims_pkg::lims_tx_par_master : lims_pkg::lims_tx_par_slave;
      if (sm == 2'h0) return lims_pkg::lims_tx_ser_clkdata;
      if (sm == 2'h2) return lims_pkg::lims_tx_ser_data;
      if (sm == 2'h1) return lims_pkg::lims_tx_ser_plesio;
      return lims_pkg::lims_tx_invalid;
   endfunction : exp_tx
   // Compare every output and the status word
   task automatic chk_all(input logic sw, input logic [2:0] rmi, input logic [1:0] ck,
                          input logic [1:0] sm, input logic pm);
      logic       v;
      logic [2:0] fcm;
      v = !(ck == 2'h1 || (ck == 2'h2 && rmi[2]));
      fcm = {!rmi[0] && sm == 2'h1, !rmi[0] && sm == 2'h0, rmi[0] && pm};
      `CHK(sw_mode, sw)
      `CHK({rate_e4, media_cmi, parallel_if}, rmi)
      `CHK(refclk_valid, v)
      `CHK(refclk_freq, exp_ref(rmi[2], ck))
      `CHK(tx_clock_scheme, exp_tx(rmi[0], sm, pm))
      `CHK({tx_fifo_bypass, tx_cdr_bypass, parallel_master}, fcm)
      ctrl.rd(`LIMS_ADDR_STAT, rb);
      `CHK(rb, {fcm, v, sw, rmi[0], rmi[1], rmi[2]})
   endtask : chk_all
   // Pin mode rounds; first nine walk every pairing of low, float and high codes on clock select and clock mode
   task automatic pin_round(input int n);
      logic [31:0] r;
      logic [1:0]  ck, cm;
      for (int i = 0; i < n; i++) begin
         r = rnd();
         ck = (i < 9) ? tri3(2'(i % 3)) : r[4:3];
         cm = (i < 9) ? tri3(2'(i / 3)) : r[6:5];
         ctrl.set_pins(1'b0, r[2:0], ck, cm);
         repeat (4) @(posedge clk);
         #1 chk_all(1'b0, r[2:0], ck, (cm == 2'h0) ? 2'h0 : {!cm[0], cm[0]}, cm == 2'h3);
      end
   endtask : pin_round
   // Values held while reset is low
   task automatic rst_chk();
      `CHK({sw_mode, rate_e4, media_cmi, parallel_if, tx_cdr_bypass, tx_fifo_bypass,
            parallel_master, refclk_valid, reg_rdata}, 16'h0900)
      `CHK(refclk_freq, lims_pkg::lims_ref_19m44)
      `CHK(tx_clock_scheme, lims_pkg::lims_tx_ser_clkdata)
   endtask : rst_chk
   // Closing verdict
   task automatic complete_run();
      $display("Comparisons %0d, mismatches %0d", compares, n_fail);
      if (n_fail == 0 && compares > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask : complete_run
   // ---------------------------------------------
   // Clock, watchdog and main sequence
   // ---------------------------------------------
   initial begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end
   initial begin
      #200000;
      n_fail++;
      complete_run();
   end
   initial begin
      logic [31:0] r;
      logic [7:0]  d;
      arst_n = 1'b0;
      repeat (8) @(posedge clk);
      #1 rst_chk();
      @(posedge clk) arst_n <= 1'b1;
      pin_round(30);
      for (int i = 0; i < 24; i++) begin
         r = rnd();
         d = r[7:0];
         ctrl.set_pins(1'b1, r[10:8], r[12:11], r[14:13]);
         ctrl.wr(`LIMS_ADDR_CFG, d);
         repeat (3) @(posedge clk);
         #1 chk_all(1'b1, {d[0], d[1], d[2]}, d[4:3], d[6:5], d[7]);
      end
      ctrl.wr(`LIMS_ADDR_STAT, ~d);
      ctrl.wr(4'hE, ~d);
      ctrl.rd(`LIMS_ADDR_CFG, rb);
      `CHK(rb, d)
      ctrl.rd(4'hF, rb);
      `CHK(rb, `LIMS_RDATA_ZERO)
      pin_round(12);
      @(posedge clk) arst_n <= 1'b0;
      repeat (2) @(posedge clk);
      #1 rst_chk();
      @(posedge clk) arst_n <= 1'b1;
      ctrl.rd(`LIMS_ADDR_CFG, rb);
      `CHK(rb, `LIMS_CFG_RESET)
      pin_round(6);
      complete_run();
   end
endmodule : tb_lims_mode_select
